// ==== decode_pkg.sv ====
package decode_pkg;

   localparam int PC_W = 12;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RAM_DEPTH = 256;

   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [PC_W-1:0] PC_STEP = 12'h001;
   localparam logic [PC_W-1:0] PC_STEP_BIT_TEST = 12'h003;
   localparam logic [PC_W-1:0] PC_STEP_BIT_OP = 12'h002;

   localparam logic [ADDR_W-1:0] ACC_ADDR = 8'hff;
   localparam logic [ADDR_W-1:0] FIRST_POINTER_ADDR = 8'h80;
   localparam logic [ADDR_W-1:0] SECOND_POINTER_ADDR = 8'h81;

   localparam logic [5:0] OP_INC_SHORT_HI = 6'h2a;
   localparam logic [5:0] OP_DEC_SHORT_HI = 6'h2e;
   localparam logic [DATA_W-1:0] OP_INC_FIRST_IND = 8'he6;
   localparam logic [DATA_W-1:0] OP_DEC_FIRST_IND = 8'he7;
   localparam logic [DATA_W-1:0] OP_INC_SECOND_IND = 8'hf6;
   localparam logic [DATA_W-1:0] OP_DEC_SECOND_IND = 8'hf7;
   localparam logic [DATA_W-1:0] OP_COPY_FIRST_POINTER_TO_ACC = 8'hac;
   localparam logic [DATA_W-1:0] OP_COPY_SECOND_POINTER_TO_ACC = 8'had;
   localparam logic [DATA_W-1:0] OP_COPY_ACC_TO_FIRST_POINTER = 8'hbc;
   localparam logic [DATA_W-1:0] OP_COPY_ACC_TO_SECOND_POINTER = 8'hbd;
   localparam logic [DATA_W-1:0] OP_SUB_RETURN = 8'hb3;
   localparam logic [DATA_W-1:0] OP_INTERRUPT_RETURN = 8'hb2;
   localparam logic [DATA_W-1:0] OP_STOP = 8'hb6;
   localparam logic [DATA_W-1:0] OP_WAIT = 8'hb7;
   localparam logic [4:0] OP_BIT_TEST_HI = 5'h18;
   localparam logic [4:0] OP_BIT_TEST_ONE_HI = 5'h19;
   localparam logic [3:0] OP_BIT_FORCE_HI = 4'hd;
   localparam logic [2:0] OP_BIT_GROUP_HI = 3'h6;

   localparam logic [1:0] COND_NONZERO = 2'h0;
   localparam logic [1:0] COND_ZERO = 2'h1;
   localparam logic [1:0] COND_NO_BORROW = 2'h2;
   localparam logic [1:0] COND_BORROW = 2'h3;

   typedef enum logic [2:0] {
      ST_FETCH  = 3'b000,
      ST_DECODE = 3'b001,
      ST_PTR    = 3'b010,
      ST_OPND   = 3'b011,
      ST_MODIFY = 3'b100,
      ST_PAD    = 3'b101,
      ST_HALT   = 3'b110
   } state_t;

endpackage

// ==== ram_byte_store.sv ====
`timescale 1ns/1ns
`default_nettype none
module ram_byte_store
(
   input  wire logic                            clock,
   input  wire logic [decode_pkg::ADDR_W-1:0]   addr,
   input  wire logic                            we,
   input  wire logic [decode_pkg::DATA_W-1:0]   wdata,
   output logic      [decode_pkg::DATA_W-1:0]   rdata
);

   // No reset on storage; contents are software's business
   logic [decode_pkg::DATA_W-1:0] mem [decode_pkg::RAM_DEPTH];

   // Plain always so the array may also be preloaded from outside this process
   always @(posedge clock)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clock)
   begin
      rdata <= mem[addr];
   end

endmodule
`default_nettype wire

// ==== rmw_branch_bit_ctrl_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module rmw_branch_bit_ctrl_decode
(
   input  wire logic                           clock,
   input  wire logic                           reset_n,
   input  wire logic [decode_pkg::DATA_W-1:0]  prog_data,
   input  wire logic [decode_pkg::PC_W-1:0]    return_pc,
   input  wire logic                           cmp_valid,
   input  wire logic [decode_pkg::DATA_W-1:0]  cmp_reg,
   input  wire logic [decode_pkg::DATA_W-1:0]  cmp_mem,
   input  wire logic                           wake_req,
   output logic      [decode_pkg::PC_W-1:0]    prog_addr,
   output logic                                zero_flag,
   output logic                                carry_flag,
   output logic                                stop_mode,
   output logic                                wait_mode,
   output logic                                sub_return,
   output logic                                int_return,
   output logic                                illegal_op
);

   typedef struct packed {
      decode_pkg::state_t              state;
      logic [decode_pkg::PC_W-1:0]     pc;
      logic [decode_pkg::PC_W-1:0]     prog_addr;
      logic [decode_pkg::DATA_W-1:0]   op;
      logic [decode_pkg::ADDR_W-1:0]   ea;
      logic                            zero;
      logic                            carry;
      logic                            stop;
      logic                            wait_s;
      logic                            sub_ret;
      logic                            int_ret;
      logic                            illegal;
      logic                            wake_s1;
      logic                            wake_s2;
   } core_t;

   core_t core_r;
   core_t core_nxt;

   logic [decode_pkg::ADDR_W-1:0] ram_addr;
   logic                          ram_we;
   logic [decode_pkg::DATA_W-1:0] ram_wdata;
   logic [decode_pkg::DATA_W-1:0] ram_rdata;

   ram_byte_store u_ram
   (
      .clock (clock),
      .addr  (ram_addr),
      .we    (ram_we),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   function automatic logic [decode_pkg::PC_W-1:0] sext5(input logic [4:0] v);
      return {{(decode_pkg::PC_W-5){v[4]}}, v};
   endfunction

   function automatic logic [decode_pkg::PC_W-1:0] sext8(input logic [7:0] v);
      return {{(decode_pkg::PC_W-8){v[7]}}, v};
   endfunction

   // Short-direct and indirect inc/dec share one datapath
   function automatic logic is_step(input logic [7:0] o);
      return (o[7:2] == decode_pkg::OP_INC_SHORT_HI) || (o[7:2] == decode_pkg::OP_DEC_SHORT_HI)
         || (o == decode_pkg::OP_INC_FIRST_IND) || (o == decode_pkg::OP_DEC_FIRST_IND)
         || (o == decode_pkg::OP_INC_SECOND_IND) || (o == decode_pkg::OP_DEC_SECOND_IND);
   endfunction

   function automatic logic is_short_copy(input logic [7:0] o);
      return (o[7:1] == decode_pkg::OP_COPY_FIRST_POINTER_TO_ACC[7:1])
         || (o[7:1] == decode_pkg::OP_COPY_ACC_TO_FIRST_POINTER[7:1]);
   endfunction

   always_comb
   begin
      logic                            take;
      logic [decode_pkg::DATA_W-1:0]   val;
      logic [decode_pkg::DATA_W-1:0]   mask;
      take = 1'b0;
      val = '0;
      mask = '0;
      core_nxt = core_r;
      core_nxt.sub_ret = 1'b0;
      core_nxt.int_ret = 1'b0;
      core_nxt.illegal = 1'b0;
      core_nxt.wake_s1 = wake_req;
      core_nxt.wake_s2 = core_r.wake_s1;
      ram_addr = '0;
      ram_we = 1'b0;
      ram_wdata = '0;
      if (cmp_valid)
      begin
         core_nxt.carry = (cmp_reg < cmp_mem);
      end
      case (core_r.state)
         decode_pkg::ST_FETCH:
         begin
            // Operand address goes out early to cover ROM latency
            core_nxt.prog_addr = core_r.pc + decode_pkg::PC_STEP;
            core_nxt.state = decode_pkg::ST_DECODE;
         end
         decode_pkg::ST_DECODE:
         begin
            core_nxt.op = prog_data;
            core_nxt.state = decode_pkg::ST_FETCH;
            if (!prog_data[7])
            begin
               case (prog_data[6:5])
                  decode_pkg::COND_NONZERO:   take = !core_r.zero;
                  decode_pkg::COND_ZERO:      take = core_r.zero;
                  decode_pkg::COND_NO_BORROW: take = !core_r.carry;
                  default:                    take = core_r.carry;
               endcase
               core_nxt.pc = core_r.pc + decode_pkg::PC_STEP;
               if (take)
               begin
                  core_nxt.pc = core_r.pc + decode_pkg::PC_STEP + sext5(prog_data[4:0]);
               end
            end
            else if (is_step(prog_data) && prog_data[6])
            begin
               // Pointer byte first, then the byte it names
               ram_addr = prog_data[4] ? decode_pkg::SECOND_POINTER_ADDR
                                       : decode_pkg::FIRST_POINTER_ADDR;
               core_nxt.state = decode_pkg::ST_PTR;
            end
            else if (is_step(prog_data) || is_short_copy(prog_data))
            begin
               core_nxt.ea = decode_pkg::FIRST_POINTER_ADDR | {6'h00, prog_data[1:0]};
               ram_addr = core_nxt.ea;
               if (prog_data[7:1] == decode_pkg::OP_COPY_ACC_TO_FIRST_POINTER[7:1])
               begin
                  ram_addr = decode_pkg::ACC_ADDR;
               end
               core_nxt.state = decode_pkg::ST_MODIFY;
            end
            else if (prog_data[7:5] == decode_pkg::OP_BIT_GROUP_HI)
            begin
               core_nxt.prog_addr = core_r.pc + decode_pkg::PC_STEP_BIT_OP;
               core_nxt.state = decode_pkg::ST_OPND;
            end
            else if (prog_data == decode_pkg::OP_SUB_RETURN)
            begin
               core_nxt.pc = return_pc;
               core_nxt.sub_ret = 1'b1;
            end
            else if (prog_data == decode_pkg::OP_INTERRUPT_RETURN)
            begin
               core_nxt.pc = return_pc;
               core_nxt.int_ret = 1'b1;
            end
            else if (prog_data == decode_pkg::OP_STOP || prog_data == decode_pkg::OP_WAIT)
            begin
               core_nxt.pc = core_r.pc + decode_pkg::PC_STEP;
               core_nxt.stop = !prog_data[0];
               core_nxt.wait_s = prog_data[0];
               core_nxt.state = decode_pkg::ST_HALT;
            end
            else
            begin
               // Unlisted opcodes skip as two-cycle no-ops
               core_nxt.pc = core_r.pc + decode_pkg::PC_STEP;
               core_nxt.illegal = 1'b1;
            end
            if (core_nxt.state == decode_pkg::ST_FETCH || core_nxt.state == decode_pkg::ST_HALT)
            begin
               core_nxt.prog_addr = core_nxt.pc;
            end
         end
         decode_pkg::ST_PTR:
         begin
            core_nxt.ea = ram_rdata;
            ram_addr = ram_rdata;
            core_nxt.state = decode_pkg::ST_MODIFY;
         end
         decode_pkg::ST_OPND:
         begin
            // Accumulator at $FF and pointers at $80/$81 are plain RAM here
            core_nxt.ea = prog_data;
            ram_addr = prog_data;
            core_nxt.state = decode_pkg::ST_MODIFY;
         end
         decode_pkg::ST_MODIFY:
         begin
            core_nxt.state = decode_pkg::ST_PAD;
            core_nxt.pc = core_r.pc + decode_pkg::PC_STEP;
            mask = 8'h01 << core_r.op[2:0];
            if (core_r.op[7:3] == decode_pkg::OP_BIT_TEST_HI
               || core_r.op[7:3] == decode_pkg::OP_BIT_TEST_ONE_HI)
            begin
               take = core_r.op[3] ? ram_rdata[core_r.op[2:0]]
                                   : !ram_rdata[core_r.op[2:0]];
               core_nxt.pc = core_r.pc + decode_pkg::PC_STEP_BIT_TEST;
               if (take)
               begin
                  core_nxt.pc = core_r.pc + decode_pkg::PC_STEP_BIT_TEST + sext8(prog_data);
               end
            end
            else if (core_r.op[7:4] == decode_pkg::OP_BIT_FORCE_HI)
            begin
               ram_we = 1'b1;
               ram_addr = core_r.ea;
               ram_wdata = core_r.op[3] ? (ram_rdata | mask) : (ram_rdata & ~mask);
               core_nxt.pc = core_r.pc + decode_pkg::PC_STEP_BIT_OP;
               core_nxt.state = decode_pkg::ST_FETCH;
            end
            else if (is_short_copy(core_r.op))
            begin
               ram_we = 1'b1;
               ram_wdata = ram_rdata;
               ram_addr = core_r.op[4] ? core_r.ea : decode_pkg::ACC_ADDR;
            end
            else
            begin
               // Decrement select differs between short and indirect forms
               if (core_r.op[6] ? core_r.op[0] : core_r.op[4])
               begin
                  val = ram_rdata - 8'h01;
               end
               else
               begin
                  val = ram_rdata + 8'h01;
               end
               ram_we = 1'b1;
               ram_addr = core_r.ea;
               ram_wdata = val;
               core_nxt.zero = (val == 8'h00);
               if (core_r.op[6])
               begin
                  core_nxt.state = decode_pkg::ST_FETCH;
               end
            end
            core_nxt.prog_addr = core_nxt.pc;
         end
         decode_pkg::ST_PAD:
         begin
            core_nxt.state = decode_pkg::ST_FETCH;
         end
         decode_pkg::ST_HALT:
         begin
            // Wake is the synchronised pin only; the raw stage is never read here
            if (core_r.wake_s2)
            begin
               core_nxt.stop = 1'b0;
               core_nxt.wait_s = 1'b0;
               core_nxt.state = decode_pkg::ST_FETCH;
            end
         end
         default:
         begin
            core_nxt.state = decode_pkg::ST_FETCH;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         core_r <= '{state: decode_pkg::ST_FETCH, pc: decode_pkg::PC_RESET,
                     prog_addr: decode_pkg::PC_RESET, default: '0};
      end
      else
      begin
         core_r <= core_nxt;
      end
   end

   assign prog_addr = core_r.prog_addr;
   assign zero_flag = core_r.zero;
   assign carry_flag = core_r.carry;
   assign stop_mode = core_r.stop;
   assign wait_mode = core_r.wait_s;
   assign sub_return = core_r.sub_ret;
   assign int_return = core_r.int_ret;
   assign illegal_op = core_r.illegal;

endmodule
`default_nettype wire

// ==== prog_rom_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module prog_rom_model
(
   input  wire logic                          clock,
   input  wire logic [decode_pkg::PC_W-1:0]   addr,
   output logic      [decode_pkg::DATA_W-1:0] data
);
   logic [decode_pkg::DATA_W-1:0] mem [(1 << decode_pkg::PC_W)];
   // Unused space is no-operations, so a run never wanders into junk
   initial
   begin
      for (int i = 0; i < (1 << decode_pkg::PC_W); i++)
         mem[i] = 8'h20;
   end
   // One cycle read latency, same as the real synchronous store
   always_ff @(posedge clock)
      data <= mem[addr];
endmodule
`default_nettype wire

// ==== decode_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module decode_checker
(
   input wire logic                          clock,
   input wire logic                          reset_n,
   input wire logic [decode_pkg::PC_W-1:0]   return_pc,
   input wire logic                          cmp_valid,
   input wire logic [decode_pkg::DATA_W-1:0] cmp_reg,
   input wire logic [decode_pkg::DATA_W-1:0] cmp_mem,
   input wire logic                          wake_req,
   input wire logic [decode_pkg::PC_W-1:0]   prog_addr,
   input wire logic                          carry_flag,
   input wire logic                          stop_mode,
   input wire logic                          wait_mode,
   input wire logic                          sub_return,
   input wire logic                          int_return
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   sequence s_cmp_low;
      cmp_valid && (cmp_reg < cmp_mem);
   endsequence
   sequence s_cmp_high;
      cmp_valid && (cmp_reg >= cmp_mem);
   endsequence
   // Two halted cycles in a row; the entry edge may still move the address
   sequence s_halted;
      (stop_mode || wait_mode) && $past(stop_mode || wait_mode);
   endsequence
   sequence s_wake;
      $rose(wake_req) && (stop_mode || wait_mode);
   endsequence
   AST_CARRY_SET:
   assert property (s_cmp_low |=> carry_flag) else $error("carry not set after lower compare");
   AST_CARRY_CLR:
   assert property (s_cmp_high |=> !carry_flag) else $error("carry not cleared");
   AST_CARRY_HOLD:
   assert property (!cmp_valid |=> $stable(carry_flag)) else $error("carry moved alone");
   AST_SUB_PULSE:
   assert property (sub_return |=> !sub_return) else $error("subroutine return too long");
   AST_INT_PULSE:
   assert property (int_return |=> !int_return) else $error("interrupt return too long");
   AST_RET_ADDR:
   assert property ((sub_return || int_return) |-> prog_addr == return_pc)
      else $error("return address not taken");
   AST_HALT_HOLD:
   assert property (s_halted |-> $stable(prog_addr)) else $error("fetch while halted");
   AST_MODE_EXCL:
   assert property (!(stop_mode && wait_mode)) else $error("stop and wait together");
   AST_WAKE:
   assert property (s_wake |-> ##[1:4] !(stop_mode || wait_mode)) else $error("no wake");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_top;
   logic                          clock, reset_n, cmp_valid, wake_req, zero_flag, carry_flag;
   logic                          stop_mode, wait_mode, sub_return, int_return, illegal_op;
   logic [decode_pkg::DATA_W-1:0] prog_data, cmp_reg, cmp_mem;
   logic [decode_pkg::PC_W-1:0]   return_pc, prog_addr, exp_pa;
   int                            mismatches, samples_checked, cycles;
   localparam logic [7:0] IA [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h90, 8'h91, 8'hff};
   localparam logic [7:0] IV [7] = '{8'h90, 8'h91, 8'hff, 8'h01, 8'hff, 8'h01, 8'h33};
   localparam logic [7:0] RO [16] = '{8'ha8, 8'ha9, 8'haa, 8'hab, 8'hb8, 8'hb9, 8'hba,
      8'hbb, 8'he6, 8'he7, 8'hf6, 8'hf7, 8'hac, 8'had, 8'hbc, 8'hbd};
   localparam logic [7:0] RA [16] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h80, 8'h81, 8'h82,
      8'h83, 8'h90, 8'h90, 8'h91, 8'h91, 8'hff, 8'hff, 8'h80, 8'h81};
   localparam logic [7:0] RE [16] = '{8'h91, 8'h92, 8'h00, 8'h02, 8'h8f, 8'h90, 8'hfe,
      8'h00, 8'h00, 8'hfe, 8'h02, 8'h00, 8'h90, 8'h91, 8'h33, 8'h33};
   localparam logic [7:0] CT [5] = '{8'hb3, 8'hb2, 8'hb6, 8'hb7, 8'h80};
   localparam logic [11:0] RET_PC = 12'h5a3;
   rmw_branch_bit_ctrl_decode DUT
   (
      .clock(clock), .reset_n(reset_n), .prog_data(prog_data), .return_pc(return_pc),
      .cmp_valid(cmp_valid), .cmp_reg(cmp_reg), .cmp_mem(cmp_mem), .wake_req(wake_req),
      .prog_addr(prog_addr), .zero_flag(zero_flag), .carry_flag(carry_flag),
      .stop_mode(stop_mode), .wait_mode(wait_mode), .sub_return(sub_return),
      .int_return(int_return), .illegal_op(illegal_op)
   );
   prog_rom_model u_rom (.clock(clock), .addr(prog_addr), .data(prog_data));
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Whole run needs about eight hundred cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         end_sim();
      end
   end
   task step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Reset mid-run on purpose, so every program starts at address zero
   task run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      @(posedge clock);
      reset_n <= 1'b0;
      u_rom.mem[0] = b0;
      u_rom.mem[1] = b1;
      u_rom.mem[2] = b2;
      for (int i = 0; i < 7; i++)
         DUT.u_ram.mem[IA[i]] = IV[i];
      @(posedge clock);
      reset_n <= 1'b1;
   endtask
   task t_branch;
      for (int g = 0; g < 4; g++)
         for (int s = 0; s < 2; s++)
         begin
            exp_pa = (g[0] != s[0]) ? 12'h002 : (s ? 12'h000 : 12'h005);
            run(8'hb8, {1'b0, g[1:0], s ? 5'h1e : 5'h03}, 8'h20);
            DUT.u_ram.mem[8'h80] = s ? 8'h01 : 8'h02;
            @(posedge clock);
            cmp_valid <= 1'b1;
            cmp_reg <= s ? 8'h10 : 8'h20;
            cmp_mem <= 8'h20;
            @(posedge clock);
            cmp_valid <= 1'b0;
            step(4);
            `CHK("dec data", s ? 8'h00 : 8'h01, DUT.u_ram.mem[8'h80]);
            `CHK("zero flag", s[0], zero_flag);
            `CHK("carry flag", s[0], carry_flag);
            `CHK("branch pc", exp_pa, prog_addr);
         end
      run(8'h20, 8'h20, 8'h20);
      step(3);
      `CHK("nop pc", 12'h002, prog_addr);
   endtask
   task t_rmw;
      for (int i = 0; i < 16; i++)
      begin
         run(RO[i], 8'h20, 8'h20);
         step(4);
         `CHK("rmw pc", 12'h001, prog_addr);
         `CHK("rmw data", RE[i], DUT.u_ram.mem[RA[i]]);
         `CHK("rmw zero", RE[i] == 8'h00, zero_flag);
      end
   endtask
   task t_bits;
      logic [7:0] ad;
      logic [7:0] v;
      for (int j = 0; j < 3; j++)
         for (int n = 0; n < 8; n++)
            for (int k = 0; k < 2; k++)
            begin
               ad = IA[(j == 2) ? 6 : j];
               v = IV[(j == 2) ? 6 : j];
               run({4'hd, k[0], n[2:0]}, ad, 8'h20);
               step(4);
               `CHK("bit op pc", 12'h002, prog_addr);
               `CHK("bit op data", k ? v | (8'h01 << n) : v & ~(8'h01 << n),
                  DUT.u_ram.mem[ad]);
               exp_pa = (v[n] != k[0]) ? 12'h003 : (k ? 12'h013 : 12'hff3);
               run({4'hc, k[0], n[2:0]}, ad, k ? 8'h10 : 8'hf0);
               step(5);
               `CHK("bit test pc", exp_pa, prog_addr);
            end
   endtask
   task t_control;
      logic [4:0] e;
      for (int i = 0; i < 5; i++)
      begin
         run(CT[i], 8'h20, 8'h20);
         step(2);
         `CHK("ctl out", 5'b10000 >> i, {sub_return, int_return, stop_mode, wait_mode,
            illegal_op});
         if (i != 2 && i != 3)
            `CHK("ctl pc", (i < 2) ? RET_PC : 12'h001, prog_addr);
         step(1);
         e = (i == 2 || i == 3) ? 5'b10000 >> i : 5'b00000;
         `CHK("ctl hold", e, {sub_return, int_return, stop_mode, wait_mode,
            illegal_op});
         if (e != 5'b00000)
         begin
            @(posedge clock);
            wake_req <= 1'b1;
            for (int w = 0; w < 8 && (stop_mode || wait_mode); w++)
               step(1);
            `CHK("wake", 13'h0001, {stop_mode | wait_mode, prog_addr});
            @(posedge clock);
            wake_req <= 1'b0;
         end
      end
   endtask
   initial
   begin
      reset_n = 1'b0;
      cmp_valid = 1'b0;
      cmp_reg = 8'h00;
      cmp_mem = 8'h00;
      wake_req = 1'b0;
      return_pc = RET_PC;
      repeat (5) @(posedge clock);
      t_branch();
      t_rmw();
      t_bits();
      t_control();
      end_sim();
   end
endmodule
bind rmw_branch_bit_ctrl_decode decode_checker u_chk
(
   .clock(clock), .reset_n(reset_n), .return_pc(return_pc), .cmp_valid(cmp_valid),
   .cmp_reg(cmp_reg), .cmp_mem(cmp_mem), .wake_req(wake_req), .prog_addr(prog_addr),
   .carry_flag(carry_flag), .stop_mode(stop_mode), .wait_mode(wait_mode),
   .sub_return(sub_return), .int_return(int_return)
);
`default_nettype wire
